// *** expo_pkg.sv ***
// constants shared by the exposure and single-capture block
// assumes a 25 MHz ref_clk and a plain register write/read port
package expo_pkg;
  // register addresses as the host sees them
  localparam logic [31:0] EXPO_COUNT_ADDR = 32'h0000081C;
  localparam logic [31:0] CONT_ADDR       = 32'hF0F00614;
  localparam logic [31:0] SINGLE_ADDR     = 32'hF0F0061C;
  localparam logic [31:0] TRIG_ADDR       = 32'hF0F00830;
  localparam logic [31:0] LONG_ADDR       = 32'hF100020C;
  localparam logic [31:0] TBASE_ADDR      = 32'hF1000208;
  localparam logic [31:0] RATE_ADDR       = 32'hF0F00600;
  localparam logic [31:0] MODE_ADDR       = 32'hF0F00604;
  localparam logic [31:0] FORMAT_ADDR     = 32'hF0F00608;
  // field positions (bit 31 is the msb of the bus word)
  localparam int ENABLE_BIT  = 31;
  localparam int PRESENT_BIT = 31;
  localparam int TRIG_ON_BIT = 25;
  // field widths
  localparam int SHUT_W = 12;
  localparam int TB_W   = 10;
  localparam int LONG_W = 22;
  localparam int DUR_W  = 23;
  localparam int LFLD_W = 26;
  // limits and reset values
  localparam logic [SHUT_W-1:0] SHUT_MIN = 12'h001;
  localparam logic [SHUT_W-1:0] SHUT_RST = 12'h001;
  localparam logic [TB_W-1:0]   TB_MIN   = 10'h001;
  localparam logic [TB_W-1:0]   TB_RST   = 10'h014;
  localparam logic [LFLD_W-1:0] LONG_MAX = 26'h03FFFFF;
  localparam logic [LONG_W-1:0] LONG_MIN = 22'h000001;
  localparam logic [LONG_W-1:0] LONG_RST = 22'h000014;
  // timing: one microsecond in clock cycles
  localparam int CLK_PERIOD_PS = 40000;
  localparam int US_PS         = 1000000;
  localparam int CYC_PER_US    = US_PS / CLK_PERIOD_PS;
  localparam int OFFSET_US_DEF = 17;
  // capture sequencer states
  typedef enum logic [1:0] {P_IDLE, P_ARMED, P_EXPOSE} phase_t;
endpackage

// *** expo_if.sv ***
// exposure request/answer bundle between the sequencer and the timer
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface expo_if;
  import expo_pkg::*;
  logic             start;   // one-cycle request to begin integration
  logic [DUR_W-1:0] dur_us;  // live target length in microseconds
  logic             busy;    // integration in progress
  logic             done;    // one-cycle end of integration
  modport ctrl (output start, output dur_us, input busy, input done);
  modport tmr  (input start, input dur_us, output busy, output done);
endinterface
`default_nettype wire

// *** expo_timer.sv ***
// microsecond integration timer
// assumes ce freezes it and dur_us may change while running
`timescale 1ns/1ps
`default_nettype none
module expo_timer
  import expo_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic ce,
  expo_if.tmr       e
);
  localparam int PW = $clog2(CYC_PER_US);

  typedef struct packed {
    logic             busy;     // counting
    logic [PW-1:0]    presc;    // cycles within the current microsecond
    logic [DUR_W-1:0] elapsed;  // whole microseconds done
  } tmr_t;

  tmr_t q_r;    // registered state
  tmr_t q_nxt;  // next state
  logic tick;   // last cycle of a microsecond
  logic fin;    // target reached

  // the target is compared live so a rewrite acts at once
  always_comb begin
    q_nxt = q_r;
    tick  = q_r.busy && (q_r.presc == PW'(CYC_PER_US - 1));
    fin   = tick && ((q_r.elapsed + 1'b1) >= e.dur_us);
    if (!q_r.busy) begin
      if (e.start) begin
        q_nxt.busy    = 1'b1;
        q_nxt.presc   = '0;
        q_nxt.elapsed = '0;
      end
    end else if (fin) begin
      q_nxt.busy = 1'b0;
    end else if (tick) begin
      q_nxt.presc   = '0;
      q_nxt.elapsed = q_r.elapsed + 1'b1;
    end else begin
      q_nxt.presc = q_r.presc + 1'b1;
    end
  end

  // clock enable freezes everything
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign e.busy = q_r.busy;
  assign e.done = fin && ce;
endmodule
`default_nettype wire

// *** trig_edge.sv ***
// rising-edge detector for the external trigger
// assumes the trigger level is already synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module trig_edge (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic level,
  output logic      rise
);
  typedef struct packed {
    logic prev;  // level seen last cycle
  } edge_t;

  edge_t q_r;
  edge_t q_nxt;

  // remember the level; a high level at reset is not an edge
  always_comb begin
    q_nxt.prev = level;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // start as if the pin were high, so a level already up is no edge
      q_r <= '1;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign rise = ce && level && !q_r.prev;
endmodule
`default_nettype wire

// *** expo_capture.sv ***
// exposure-time control and single-capture sequencer
// assumes the host uses the reg_* port; ext_trigger is synchronous
//
// Behaviour
// - exposure is count times base plus offset, or the long value plus offset in long mode
// - shutter count held within 1 to 4095
// - time base resets to twenty microseconds
// - fixed per-model offset added to every exposure
// - shortest programmable exposure is one microsecond
// - long register: present flag, microsecond field
// - long field saturates at 3FFFFF microseconds
// - long field never below the minimum
// - shutter writes mirror into long, not back
// - long writes act at once, mid-frame
// - format, mode, rate writes drop long mode
// - single bit takes one image, then clears
// - continuous mode ignores the single bit
// - trigger mode: single bit arms, edge captures
// - clearing an armed single bit cancels it
// - continuous bit starts and stops free-run
`timescale 1ns/1ps
`default_nettype none
module expo_capture
  import expo_pkg::*;
#(
  parameter int unsigned OFFSET_US = OFFSET_US_DEF  // per-model offset
)(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  input  wire logic        ext_trigger,
  output logic             exposing,
  output logic             frame_done
);
  // offset must fit the duration sum and be at least one microsecond
  if (OFFSET_US < 1 || OFFSET_US > 1023) begin : g_bad_offset
    $error("OFFSET_US out of range");
  end

  typedef struct packed {
    logic [SHUT_W-1:0] shut;     // standard shutter count
    logic [TB_W-1:0]   tb;       // time base in microseconds
    logic [LONG_W-1:0] long_us;  // long exposure in microseconds
    logic              long_act; // long value steers exposure
    logic              cont;     // free-running capture
    logic              single;   // single-capture bit
    logic              trig_on;  // edge-trigger mode
    logic              shot;     // current exposure is a single one
    phase_t            phase;    // sequencer state
    logic              fdone;    // frame finished pulse
    logic [31:0]       rdata;    // read data
  } ctl_t;

  ctl_t q_r;    // registered state
  ctl_t q_nxt;  // next state

  localparam ctl_t CTL_RST = '{
    shut: SHUT_RST, tb: TB_RST, long_us: LONG_RST, long_act: 1'b0,
    cont: 1'b0, single: 1'b0, trig_on: 1'b0, shot: 1'b0,
    phase: P_IDLE, fdone: 1'b0, rdata: 32'h00000000};

  expo_if bus ();       // request bundle to the timer
  logic   trig_rise;    // external trigger edge
  logic   wr_single;    // host write to the single register
  logic [DUR_W-1:0] base_dur; // duration before offset

  // the product fits 22 bits, so the mirror never saturates
  function automatic logic [LONG_W-1:0] shut_prod(
    input logic [SHUT_W-1:0] c, input logic [TB_W-1:0] t);
    shut_prod = c * t;
  endfunction

  // address match, used by write and read decode
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  expo_timer u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .e       (bus)
  );

  trig_edge u_edge (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .level   (ext_trigger),
    .rise    (trig_rise)
  );

  // duration seen live by the timer
  always_comb begin
    base_dur = q_r.long_act ? DUR_W'(q_r.long_us)
                            : DUR_W'(shut_prod(q_r.shut, q_r.tb));
  end
  assign bus.dur_us = base_dur + DUR_W'(OFFSET_US);
  assign wr_single  = reg_wr && hit(reg_addr, SINGLE_ADDR);

  // sequencer first, then host writes, so a host set wins a clear
  always_comb begin
    q_nxt       = q_r;
    q_nxt.fdone = 1'b0;
    bus.start   = 1'b0;
    case (q_r.phase)
      P_IDLE: begin
        if (q_r.cont) begin
          // free-run has priority; the single bit just waits
          bus.start   = 1'b1;
          q_nxt.shot  = 1'b0;
          q_nxt.phase = P_EXPOSE;
        end else if (q_r.single) begin
          if (q_r.trig_on) begin
            q_nxt.phase = P_ARMED;
          end else begin
            bus.start   = 1'b1;
            q_nxt.shot  = 1'b1;
            q_nxt.phase = P_EXPOSE;
          end
        end
      end
      P_ARMED: begin
        if (!q_r.single || q_r.cont || !q_r.trig_on) begin
          q_nxt.phase = P_IDLE;
        end else if (trig_rise) begin
          bus.start   = 1'b1;
          q_nxt.shot  = 1'b1;
          q_nxt.phase = P_EXPOSE;
        end
      end
      P_EXPOSE: begin
        if (bus.done) begin
          q_nxt.fdone = 1'b1;
          q_nxt.phase = P_IDLE;
          if (q_r.shot) begin
            q_nxt.single = 1'b0;
          end
        end
      end
      default: begin
        q_nxt.phase = P_IDLE;
      end
    endcase

    // host writes
    if (reg_wr) begin
      if (hit(reg_addr, EXPO_COUNT_ADDR)) begin
        // zero is lifted to one; only the low 12 bits are kept, up to 4095
        q_nxt.shut = (reg_wdata[SHUT_W-1:0] == '0) ? SHUT_MIN
                                                   : reg_wdata[SHUT_W-1:0];
        q_nxt.long_us = shut_prod(q_nxt.shut, q_r.tb);
      end
      if (hit(reg_addr, LONG_ADDR)) begin
        // long writes leave the shutter count untouched
        if (reg_wdata[LFLD_W-1:0] > LONG_MAX) begin
          q_nxt.long_us = LONG_MAX[LONG_W-1:0];
        end else if (reg_wdata[LFLD_W-1:0] == '0) begin
          q_nxt.long_us = LONG_MIN;
        end else begin
          q_nxt.long_us = reg_wdata[LONG_W-1:0];
        end
        q_nxt.long_act = 1'b1;
      end
      if (hit(reg_addr, TBASE_ADDR)) begin
        q_nxt.tb = (reg_wdata[TB_W-1:0] == '0) ? TB_MIN : reg_wdata[TB_W-1:0];
      end
      if (hit(reg_addr, CONT_ADDR)) begin
        q_nxt.cont = reg_wdata[ENABLE_BIT];
      end
      if (wr_single) begin
        q_nxt.single = reg_wdata[ENABLE_BIT];
      end
      if (hit(reg_addr, TRIG_ADDR)) begin
        q_nxt.trig_on = reg_wdata[TRIG_ON_BIT];
      end
      if (hit(reg_addr, FORMAT_ADDR) || hit(reg_addr, MODE_ADDR) ||
          hit(reg_addr, RATE_ADDR)) begin
        q_nxt.long_act = 1'b0;
      end
    end

    // reads; unmapped addresses return zero
    if (reg_rd) begin
      q_nxt.rdata = 32'h00000000;
      if (hit(reg_addr, EXPO_COUNT_ADDR)) begin
        q_nxt.rdata[SHUT_W-1:0] = q_r.shut;
      end
      if (hit(reg_addr, LONG_ADDR)) begin
        q_nxt.rdata[PRESENT_BIT]  = 1'b1;
        q_nxt.rdata[LONG_W-1:0]   = q_r.long_us;
      end
      if (hit(reg_addr, TBASE_ADDR)) begin
        q_nxt.rdata[TB_W-1:0] = q_r.tb;
      end
      if (hit(reg_addr, CONT_ADDR)) begin
        q_nxt.rdata[ENABLE_BIT] = q_r.cont;
      end
      if (hit(reg_addr, SINGLE_ADDR)) begin
        q_nxt.rdata[ENABLE_BIT] = q_r.single;
      end
      if (hit(reg_addr, TRIG_ADDR)) begin
        q_nxt.rdata[PRESENT_BIT] = 1'b1;
        q_nxt.rdata[TRIG_ON_BIT] = q_r.trig_on;
      end
    end
  end

  // one register for the whole state; ce freezes it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q_r <= CTL_RST;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  // outputs come straight from the state register, so they never glitch
  assign reg_rdata  = q_r.rdata;
  assign exposing   = (q_r.phase == P_EXPOSE);
  assign frame_done = q_r.fdone;

  // checks; frozen cycles are skipped
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !ce);

  sequence s_armed_idle;
    q_r.phase == P_ARMED && !trig_rise && !q_r.cont;
  endsequence
  sequence s_clear_write;
    wr_single && !reg_wdata[ENABLE_BIT];
  endsequence
  sequence s_shot_end;
    q_r.phase == P_EXPOSE && bus.done && q_r.shot;
  endsequence
  sequence s_edge_armed;
    q_r.phase == P_ARMED && q_r.single && q_r.trig_on && !q_r.cont && trig_rise;
  endsequence

  // behaviour checks; chk_single_clear, chk_arm_wait, chk_cancel and chk_edge_start are built on the sequences above

  chk_shut_range: assert property (q_r.shut != '0)
    else $error("shutter count left range");
  chk_tb_default: assert property ($fell(srst) |-> q_r.tb == TB_RST)
    else $error("time base not default after reset");
  chk_dur_offset: assert property (bus.start |->
    bus.dur_us == (q_r.long_act ? DUR_W'(q_r.long_us)
                                : DUR_W'(q_r.shut) * DUR_W'(q_r.tb)) + DUR_W'(OFFSET_US))
    else $error("exposure duration wrong");
  chk_min_exposure: assert property (bus.start |->
    bus.dur_us >= DUR_W'(OFFSET_US + 1))
    else $error("exposure below minimum");
  chk_long_limits: assert property (q_r.long_us >= LONG_MIN &&
    DUR_W'(q_r.long_us) <= DUR_W'(LONG_MAX))
    else $error("long exposure out of limits");
  chk_long_mirror: assert property ((reg_wr && hit(reg_addr, EXPO_COUNT_ADDR)
    && !hit(reg_addr, TBASE_ADDR)) |=> q_r.long_us == shut_prod(q_r.shut, q_r.tb))
    else $error("shutter not mirrored");
  chk_long_keeps: assert property ((reg_wr && hit(reg_addr, LONG_ADDR))
    |=> $stable(q_r.shut) && q_r.long_act)
    else $error("long write changed shutter");
  chk_mode_drop: assert property ((reg_wr && hit(reg_addr, FORMAT_ADDR))
    |=> !q_r.long_act)
    else $error("long mode survived format write");
  chk_single_clear: assert property ((s_shot_end and
    !(wr_single && reg_wdata[ENABLE_BIT])) |=> !q_r.single && !exposing)
    else $error("single bit not cleared");
  chk_cont_ignore: assert property ((q_r.cont && q_r.phase == P_IDLE)
    |=> exposing && !q_r.shot)
    else $error("free-run did not start");
  chk_arm_wait: assert property ((s_armed_idle and q_r.single
    and q_r.trig_on) |=> !exposing)
    else $error("armed capture without edge");
  chk_cancel: assert property ((s_armed_idle and s_clear_write)
    |=> ##1 q_r.phase == P_IDLE)
    else $error("armed capture not cancelled");
  // the timer and the sequencer must agree on when light is gathered
  chk_busy_track: assert property (exposing == bus.busy)
    else $error("sequencer and timer disagree");
  // an edge while armed starts exactly one single exposure
  chk_edge_start: assert property (s_edge_armed |=> exposing && q_r.shot)
    else $error("armed edge did not start capture");
  // end of frame is a single-cycle pulse
  chk_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame done pulse too long");
  // rate and mode writes drop long mode just like format writes
  chk_rate_drop: assert property ((reg_wr && (hit(reg_addr, MODE_ADDR) ||
    hit(reg_addr, RATE_ADDR))) |=> !q_r.long_act)
    else $error("long mode survived rate or mode write");
  // free-run leaves a pending single bit alone
  chk_single_held: assert property ((q_r.cont && q_r.single && !q_r.shot &&
    !wr_single) |=> q_r.single)
    else $error("single bit dropped in free-run");
  // free-run or trigger off takes an armed capture back to idle
  chk_arm_exit: assert property ((q_r.phase == P_ARMED && (q_r.cont || !q_r.trig_on))
    |=> q_r.phase == P_IDLE)
    else $error("armed state kept after mode change");
endmodule
`default_nettype wire

// *** host_bus.sv ***
// host-side register master for the exposure and single-capture block
// assumes the bench calls its tasks; strobes change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module host_bus
  import expo_pkg::*;
(
  input  wire logic        ref_clk,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [31:0] reg_addr,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'hFFFFFFFF;
    reg_wdata = 32'hFFFFFFFF;
  end
  // one word written; released lines carry the inverse so stale values never pass
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // one word read; data taken a full cycle after the strobe edge
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
  // stop free-run, select edge trigger, then arm the single capture
  task automatic arm_triggered();
    wr(CONT_ADDR, 32'h00000000);
    wr(TRIG_ADDR, 32'h82000000);
    wr(SINGLE_ADDR, 32'h80000000);
  endtask
endmodule
`default_nettype wire

// *** test_exposure_and_single_capture_ctrl.sv ***
// self-checking bench for the exposure and single-capture block
// assumes expo_pkg, expo_if and the design modules are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_exposure_and_single_capture_ctrl;
  import expo_pkg::*;
  localparam int unsigned OFS = 2;  // small offset keeps frames short
  logic        ref_clk = 1'b0;      // 25 MHz clock
  logic        srst = 1'b1;         // synchronous reset
  logic        ce = 1'b1;           // clock enable, held on
  logic        ext_trigger = 1'b0;  // external trigger level
  logic        reg_wr;              // host write strobe
  logic        reg_rd;              // host read strobe
  logic [31:0] reg_addr;            // host address
  logic [31:0] reg_wdata;           // host write data
  logic [31:0] reg_rdata;           // read answer
  logic        exposing;            // integration in progress
  logic        frame_done;          // end-of-frame pulse
  logic [31:0] hi_cnt = 32'h0;      // length of the current exposure
  logic [31:0] v;                   // scratch read value
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  always #20 ref_clk = ~ref_clk;
  host_bus host_u (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  expo_capture #(.OFFSET_US(OFS)) dut_u (.ref_clk(ref_clk), .srst(srst), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ext_trigger(ext_trigger), .exposing(exposing),
    .frame_done(frame_done));
  // exposure length counter; holds the full length on the frame_done cycle
  always @(posedge ref_clk) begin
    hi_cnt <= (exposing === 1'b1) ? hi_cnt + 32'h1 : 32'h0;
  end
  // hang guard, far above the thousand or so cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounded wait for the end of the current frame
  task automatic wait_done();
    int k;
    k = 0;
    while (frame_done !== 1'b1 && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    check(frame_done, 1'b1);
  endtask
  // reset values and an unmapped read
  task automatic t_reset();
    host_u.rd(EXPO_COUNT_ADDR, v);
    check(v, 32'h00000001);
    host_u.rd(LONG_ADDR, v);
    check(v, 32'h80000014);
    host_u.rd(SINGLE_ADDR, v);
    check(v, 32'h00000000);
    host_u.rd(32'h00000000, v);
    check(v, 32'h00000000);
  endtask
  // clamping and one-way mirroring between the two shutter registers
  task automatic t_regs();
    host_u.wr(TBASE_ADDR, 32'h00000001);
    host_u.wr(EXPO_COUNT_ADDR, 32'h00000000);
    host_u.rd(EXPO_COUNT_ADDR, v);
    check(v, 32'h00000001);
    host_u.wr(EXPO_COUNT_ADDR, 32'h00000003);
    host_u.rd(LONG_ADDR, v);
    check(v, 32'h80000003);
    host_u.wr(LONG_ADDR, 32'h03FFFFFF);
    host_u.rd(LONG_ADDR, v);
    check(v, 32'h803FFFFF);
    host_u.rd(EXPO_COUNT_ADDR, v);
    check(v, 32'h00000003);
    host_u.wr(LONG_ADDR, 32'h00000000);
    host_u.rd(LONG_ADDR, v);
    check(v, 32'h80000001);
  endtask
  // format write drops long mode; single shot of (3*1+OFS) us, bit self-clears
  task automatic t_single();
    host_u.wr(FORMAT_ADDR, 32'h00000000);
    host_u.wr(SINGLE_ADDR, 32'h80000000);
    wait_done();
    check(hi_cnt, (3 + OFS) * CYC_PER_US);
    host_u.rd(SINGLE_ADDR, v);
    check(v, 32'h00000000);
  endtask
  // long value rewritten in mid-exposure stretches the running frame
  task automatic t_long();
    host_u.wr(LONG_ADDR, 32'h00000001);
    host_u.wr(SINGLE_ADDR, 32'h80000000);
    host_u.wr(LONG_ADDR, 32'h0000000A);
    wait_done();
    check(hi_cnt, (10 + OFS) * CYC_PER_US);
    host_u.wr(MODE_ADDR, 32'h00000000);
  endtask
  // free-run restarts on its own, keeps the single bit set, and stops
  task automatic t_cont();
    host_u.wr(CONT_ADDR, 32'h80000000);
    wait_done();
    check(hi_cnt, (3 + OFS) * CYC_PER_US);
    host_u.wr(SINGLE_ADDR, 32'h80000000);
    wait_done();
    repeat (3) @(negedge ref_clk);
    check(exposing, 1'b1);
    host_u.rd(SINGLE_ADDR, v);
    check(v, 32'h80000000);
    host_u.wr(SINGLE_ADDR, 32'h00000000);
    host_u.wr(CONT_ADDR, 32'h00000000);
    wait_done();
    repeat (5) @(negedge ref_clk);
    check(exposing, 1'b0);
  endtask
  // arming waits for one edge, takes one image; a cleared arm takes none
  task automatic t_trig();
    // a rate write must drop the long value, or the frame below runs 42 us
    host_u.wr(LONG_ADDR, 32'h00000028);
    host_u.wr(RATE_ADDR, 32'h00000000);
    host_u.arm_triggered();
    repeat (5) @(negedge ref_clk);
    check(exposing, 1'b0);
    ext_trigger = 1'b1;
    wait_done();
    check(hi_cnt, (3 + OFS) * CYC_PER_US);
    host_u.rd(SINGLE_ADDR, v);
    check(v, 32'h00000000);
    ext_trigger = 1'b0;
    @(negedge ref_clk);
    ext_trigger = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(exposing, 1'b0);
    ext_trigger = 1'b0;
    host_u.wr(SINGLE_ADDR, 32'h80000000);
    repeat (3) @(negedge ref_clk);
    host_u.wr(SINGLE_ADDR, 32'h00000000);
    repeat (3) @(negedge ref_clk);
    ext_trigger = 1'b1;
    repeat (4) @(negedge ref_clk);
    check(exposing, 1'b0);
    ext_trigger = 1'b0;
  endtask
  // main sequence, with a second reset after the last test
  initial begin
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    t_reset();
    t_regs();
    t_single();
    t_long();
    t_cont();
    t_trig();
    @(negedge ref_clk);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    host_u.rd(LONG_ADDR, v);
    check(v, 32'h80000014);
    report_and_stop();
  end
endmodule
`default_nettype wire
